// ==== include/rsc_cfg.svh ====
// Register offsets, field positions, reset values and divider constants of the strap/clock/irq block
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Register byte offsets
`define RSC_OFS_STRAP 5'h00
`define RSC_OFS_CTRL 5'h04
`define RSC_OFS_IRQ_STAT 5'h08
`define RSC_OFS_IRQ_CLR 5'h0c
`define RSC_OFS_IRQ_EN 5'h10
`define RSC_OFS_TMR_PER 5'h14
`define RSC_OFS_LIVE 5'h18

// Strap register fields
`define RSC_ST_RATIO_LO 0
`define RSC_ST_CODE_LO 2
`define RSC_ST_BIG 5
`define RSC_ST_PROTO 6

// Control register fields
`define RSC_CTRL_HALT 0
`define RSC_CTRL_DOZE 1

// Interrupt status bits: 0..3 general requests, then nmi and timer
`define RSC_IRQ_GP_LO 0
`define RSC_IRQ_NMI 4
`define RSC_IRQ_TMR 5

// Live register fields
`define RSC_LV_GP_LO 0
`define RSC_LV_NMI 4
`define RSC_LV_PLL 5
`define RSC_LV_LP 6
`define RSC_LV_TINH 7

// Ratio strap values and the matching ratio codes
`define RSC_STRAP_R4 2'h0
`define RSC_STRAP_R25 2'h1
`define RSC_STRAP_R2 2'h2
`define RSC_STRAP_R3 2'h3
`define RSC_CODE_R4 3'h2
`define RSC_CODE_R25 3'h7
`define RSC_CODE_R2 3'h0
`define RSC_CODE_R3 3'h1

// Divider counts in half cycles: twice the ratio
`define RSC_MOD_R4 4'h8
`define RSC_MOD_R25 4'h5
`define RSC_MOD_R2 4'h4
`define RSC_MOD_R3 4'h6
`define RSC_DIV_STEP 4'h2

// Bus byte lanes
`define RSC_LANES 4
`define RSC_LANE_W 8

// Reset values
`define RSC_TMR_PER_RST 16'h0000
`define RSC_TMR_ONE 16'h0001
`define RSC_IRQ_EN_RST 6'h00

`endif

// ==== include/rsc_pkg.sv ====
// Types of the strap/clock/irq block
package rsc_pkg;

  typedef logic [1:0] rsc_ratio_t;
  typedef logic [2:0] rsc_code_t;
  typedef logic [3:0] rsc_gpi_t;
  typedef logic [5:0] rsc_irq_t;
  typedef logic [3:0] rsc_acc_t;
  typedef logic [15:0] rsc_tmr_t;
  typedef logic [31:0] rsc_word_t;
  typedef logic [4:0] rsc_addr_t;

  typedef struct packed {
    logic captured;
    rsc_ratio_t ratio_strap;
    rsc_code_t ratio_code;
    logic big_endian;
    logic proto9;
    rsc_gpi_t gpi_s1;
    rsc_gpi_t gpi_s2;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_prev;
    rsc_irq_t irq_status;
    rsc_irq_t irq_enable;
    logic halt;
    logic doze;
    rsc_tmr_t tmr_period;
    rsc_tmr_t tmr_count;
    rsc_acc_t div_acc;
    logic bus_clk_en;
    logic irq;
    logic nmi;
    logic low_power;
    logic pll_run;
    logic waitreq;
    rsc_word_t rdata;
  } rsc_state_s;

endpackage

// ==== rtl/rsc_ctrl.sv ====
// Strap capture, bus clock divider, interrupt sampling and low-power control
//
// Behaviour
// - Ratio strap 00,01,10,11 selects 1:4,1:2.5,1:2,1:3 with codes 010,111,000,001.
// - Timer interrupt allowed while inhibit input low, suppressed while high.
// - Low-power output high while halt or doze state is active.
// - Byte order strap at reset: 0 little-endian, 1 big-endian.
// - Four active-low general interrupt inputs sampled every rising clock edge.
// - Active-low nmi sampled every rising edge; software cannot mask it.
// - Bus clock enable divider starts in step with cold reset release.
// - PLL halt input low stops clock generation; high lets it run.
// - Protocol strap at reset: low 5-bit-command, high 9-bit-command protocol.

`include "rsc_cfg.svh"

module rsc_ctrl (
  // Clock and cold reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Straps
  input wire logic [1:0] i_clock_ratio_strap,
  input wire logic i_byte_order_strap,
  input wire logic i_bus_protocol_strap,
  // Control pins
  input wire logic i_pll_halt_n,
  input wire logic i_timer_irq_inhibit,
  // Interrupt pins, active low
  input wire logic [3:0] i_gp_irq_n,
  input wire logic i_nmi_n,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Captured configuration
  output logic [2:0] o_ratio_code_field,
  output logic o_big_endian,
  output logic o_protocol_9bit,
  // Clocking
  output logic o_system_bus_clock_en,
  output logic o_core_clock_run,
  // Status and interrupts
  output logic o_low_power_indicator,
  output logic o_irq,
  output logic o_nmi
);

  rsc_pkg::rsc_state_s st;
  rsc_pkg::rsc_state_s next_st;

  // Ratio code for a strap value
  function automatic rsc_pkg::rsc_code_t code_of(input rsc_pkg::rsc_ratio_t s);
    rsc_pkg::rsc_code_t c;
    case (s)
      `RSC_STRAP_R4: c = `RSC_CODE_R4;
      `RSC_STRAP_R25: c = `RSC_CODE_R25;
      `RSC_STRAP_R2: c = `RSC_CODE_R2;
      `RSC_STRAP_R3: c = `RSC_CODE_R3;
      default: c = `RSC_CODE_R2;
    endcase
    return c;
  endfunction

  // Divider modulus in half cycles for a ratio code
  function automatic rsc_pkg::rsc_acc_t mod_of(input rsc_pkg::rsc_code_t c);
    rsc_pkg::rsc_acc_t m;
    case (c)
      `RSC_CODE_R4: m = `RSC_MOD_R4;
      `RSC_CODE_R25: m = `RSC_MOD_R25;
      `RSC_CODE_R2: m = `RSC_MOD_R2;
      `RSC_CODE_R3: m = `RSC_MOD_R3;
      default: m = `RSC_MOD_R2;
    endcase
    return m;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic rsc_pkg::rsc_word_t be_merge(
    input rsc_pkg::rsc_word_t old_w,
    input rsc_pkg::rsc_word_t new_w,
    input logic [3:0] be
  );
    rsc_pkg::rsc_word_t r;
    r = old_w;
    for (int i = 0; i < `RSC_LANES; i++) begin
      if (be[i]) begin
        r[i*`RSC_LANE_W +: `RSC_LANE_W] = new_w[i*`RSC_LANE_W +: `RSC_LANE_W];
      end
    end
    return r;
  endfunction

  always_comb begin
    rsc_pkg::rsc_acc_t div_sum;
    rsc_pkg::rsc_acc_t div_mod;
    rsc_pkg::rsc_irq_t evt;
    rsc_pkg::rsc_irq_t clr;
    rsc_pkg::rsc_irq_t unmaskable;
    rsc_pkg::rsc_word_t rd;
    rsc_pkg::rsc_word_t wr;
    rsc_pkg::rsc_word_t cur;
    logic clk_run;
    logic tmr_hit;
    logic req;
    logic commit_wr;
    logic wake;

    // Every local starts from a known value
    next_st = st;
    div_sum = '0;
    div_mod = mod_of(st.ratio_code);
    evt = '0;
    clr = '0;
    unmaskable = '0;
    rd = '0;
    wr = '0;
    cur = '0;
    tmr_hit = 1'b0;
    clk_run = 1'b0;
    wake = 1'b0;
    req = i_avs_read | i_avs_write;
    commit_wr = i_avs_write & ~st.waitreq;

    // Straps are taken on the first edge after reset release only
    if (!st.captured) begin
      next_st.captured = 1'b1;
      next_st.ratio_strap = i_clock_ratio_strap;
      next_st.ratio_code = code_of(i_clock_ratio_strap);
      next_st.big_endian = i_byte_order_strap;
      next_st.proto9 = i_bus_protocol_strap;
    end

    // Two-stage synchronisers, then a history stage for the nmi edge
    next_st.gpi_s1 = i_gp_irq_n;
    next_st.gpi_s2 = st.gpi_s1;
    next_st.nmi_s1 = i_nmi_n;
    next_st.nmi_s2 = st.nmi_s1;
    next_st.nmi_prev = st.nmi_s2;

    // Bus clock enable: accumulate half cycles, pulse on wrap
    clk_run = st.captured & i_pll_halt_n;
    if (!clk_run) begin
      next_st.div_acc = '0;
      next_st.bus_clk_en = 1'b0;
    end else begin
      div_sum = st.div_acc + `RSC_DIV_STEP;
      if (div_sum >= div_mod) begin
        next_st.div_acc = div_sum - div_mod;
        next_st.bus_clk_en = 1'b1;
      end else begin
        next_st.div_acc = div_sum;
        next_st.bus_clk_en = 1'b0;
      end
    end
    next_st.pll_run = i_pll_halt_n;

    // Internal timer counts bus clock pulses; zero period stops it
    if (clk_run && st.bus_clk_en && st.tmr_period != `RSC_TMR_PER_RST) begin
      if (st.tmr_count >= st.tmr_period - `RSC_TMR_ONE) begin
        next_st.tmr_count = '0;
        tmr_hit = 1'b1;
      end else begin
        next_st.tmr_count = st.tmr_count + `RSC_TMR_ONE;
      end
    end

    // Events
    evt[`RSC_IRQ_GP_LO +: $bits(rsc_pkg::rsc_gpi_t)] = ~st.gpi_s2;
    evt[`RSC_IRQ_NMI] = st.nmi_prev & ~st.nmi_s2;
    evt[`RSC_IRQ_TMR] = tmr_hit & ~i_timer_irq_inhibit;

    // Register read mux, loaded at the edge that drops waitrequest
    case (i_avs_address)
      `RSC_OFS_STRAP: begin
        rd[`RSC_ST_RATIO_LO +: $bits(rsc_pkg::rsc_ratio_t)] = st.ratio_strap;
        rd[`RSC_ST_CODE_LO +: $bits(rsc_pkg::rsc_code_t)] = st.ratio_code;
        rd[`RSC_ST_BIG] = st.big_endian;
        rd[`RSC_ST_PROTO] = st.proto9;
      end
      `RSC_OFS_CTRL: begin
        rd[`RSC_CTRL_HALT] = st.halt;
        rd[`RSC_CTRL_DOZE] = st.doze;
      end
      `RSC_OFS_IRQ_STAT: begin
        rd[$bits(rsc_pkg::rsc_irq_t)-1:0] = st.irq_status;
      end
      `RSC_OFS_IRQ_EN: begin
        rd[$bits(rsc_pkg::rsc_irq_t)-1:0] = st.irq_enable;
      end
      `RSC_OFS_TMR_PER: begin
        rd[$bits(rsc_pkg::rsc_tmr_t)-1:0] = st.tmr_period;
      end
      `RSC_OFS_LIVE: begin
        rd[`RSC_LV_GP_LO +: $bits(rsc_pkg::rsc_gpi_t)] = ~st.gpi_s2;
        rd[`RSC_LV_NMI] = ~st.nmi_s2;
        rd[`RSC_LV_PLL] = st.pll_run;
        rd[`RSC_LV_LP] = st.low_power;
        rd[`RSC_LV_TINH] = i_timer_irq_inhibit;
      end
      default: begin
        rd = '0;
      end
    endcase

    // Avalon handshake: one wait cycle, then one cycle with waitrequest low
    if (st.waitreq) begin
      if (req) begin
        next_st.waitreq = 1'b0;
        next_st.rdata = rd;
      end
    end else begin
      next_st.waitreq = 1'b1;
    end

    // Writes take effect at the edge that sees waitrequest low
    if (commit_wr) begin
      case (i_avs_address)
        `RSC_OFS_CTRL: begin
          cur = '0;
          cur[`RSC_CTRL_HALT] = st.halt;
          cur[`RSC_CTRL_DOZE] = st.doze;
          wr = be_merge(cur, i_avs_writedata, i_avs_byteenable);
          next_st.halt = wr[`RSC_CTRL_HALT];
          next_st.doze = wr[`RSC_CTRL_DOZE];
        end
        `RSC_OFS_IRQ_CLR: begin
          wr = be_merge('0, i_avs_writedata, i_avs_byteenable);
          clr = wr[$bits(rsc_pkg::rsc_irq_t)-1:0];
        end
        `RSC_OFS_IRQ_EN: begin
          cur = '0;
          cur[$bits(rsc_pkg::rsc_irq_t)-1:0] = st.irq_enable;
          wr = be_merge(cur, i_avs_writedata, i_avs_byteenable);
          next_st.irq_enable = wr[$bits(rsc_pkg::rsc_irq_t)-1:0];
        end
        `RSC_OFS_TMR_PER: begin
          cur = '0;
          cur[$bits(rsc_pkg::rsc_tmr_t)-1:0] = st.tmr_period;
          wr = be_merge(cur, i_avs_writedata, i_avs_byteenable);
          next_st.tmr_period = wr[$bits(rsc_pkg::rsc_tmr_t)-1:0];
          next_st.tmr_count = '0;
        end
        default: begin
          wr = '0;
        end
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle
    next_st.irq_status = (st.irq_status & ~clr) | evt;

    // Nmi reaches the interrupt line whatever the enable register holds
    unmaskable[`RSC_IRQ_NMI] = 1'b1;
    next_st.irq = |(next_st.irq_status & (next_st.irq_enable | unmaskable));
    next_st.nmi = next_st.irq_status[`RSC_IRQ_NMI];

    // A pending enabled interrupt or nmi ends halt and doze
    // It also overrides a control write in the same cycle
    wake = |(st.irq_status & (st.irq_enable | unmaskable));
    if (wake) begin
      next_st.halt = 1'b0;
      next_st.doze = 1'b0;
    end
    next_st.low_power = next_st.halt | next_st.doze;
  end

  // Synchroniser and history flops reset to the idle pin level, so no false edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.gpi_s1 <= '1;
      st.gpi_s2 <= '1;
      st.nmi_s1 <= 1'b1;
      st.nmi_s2 <= 1'b1;
      st.nmi_prev <= 1'b1;
      st.irq_enable <= `RSC_IRQ_EN_RST;
      st.tmr_period <= `RSC_TMR_PER_RST;
      st.waitreq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_avs_readdata = st.rdata;
  assign o_avs_waitrequest = st.waitreq;
  assign o_ratio_code_field = st.ratio_code;
  assign o_big_endian = st.big_endian;
  assign o_protocol_9bit = st.proto9;
  assign o_system_bus_clock_en = st.bus_clk_en;
  assign o_core_clock_run = st.pll_run;
  assign o_low_power_indicator = st.low_power;
  assign o_irq = st.irq;
  assign o_nmi = st.nmi;

endmodule

// ==== bench/rsc_ctrl_asserts.sv ====
// Assertion checker for the strap, clock and interrupt block
module rsc_ctrl_asserts (
  // Clock, reset and pins
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_clock_ratio_strap,
  input wire logic i_byte_order_strap,
  input wire logic i_bus_protocol_strap,
  input wire logic i_pll_halt_n,
  input wire logic i_nmi_n,
  // Outputs watched
  input wire logic [2:0] o_ratio_code_field,
  input wire logic o_big_endian,
  input wire logic o_protocol_9bit,
  input wire logic o_system_bus_clock_en,
  input wire logic o_core_clock_run,
  input wire logic o_irq,
  input wire logic o_nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [11:0] lut;
  assign lut = {3'h1, 3'h0, 3'h7, 3'h2};
  a_code_map: assert property ($rose(i_arst_n) ##1 1 |->
    o_ratio_code_field == lut[3 * $past(i_clock_ratio_strap) +: 3]) else $error("ratio code wrong");
  a_endian_cap: assert property ($rose(i_arst_n) ##1 1 |->
    o_big_endian == $past(i_byte_order_strap)) else $error("byte order wrong");
  a_proto_cap: assert property ($rose(i_arst_n) ##1 1 |->
    o_protocol_9bit == $past(i_bus_protocol_strap)) else $error("protocol wrong");
  a_cfg_hold: assert property ($past(i_arst_n, 2) |-> $stable(o_ratio_code_field) &&
    $stable(o_big_endian) && $stable(o_protocol_9bit)) else $error("straps not held");
  a_bus_start: assert property ($rose(i_arst_n) && i_pll_halt_n |->
    !o_system_bus_clock_en [*2] ##[1:8] o_system_bus_clock_en) else $error("bus clock start");
  a_pll_stop: assert property (!i_pll_halt_n [*2] |=>
    !o_system_bus_clock_en && !o_core_clock_run) else $error("runs while halted");
  a_nmi_irq: assert property (o_nmi |-> o_irq) else $error("nmi masked");
  a_nmi_lat: assert property ($fell(i_nmi_n) |-> ##[2:6] o_nmi) else $error("nmi late");
  a_nmi_sync: assert property ($rose(o_nmi) |-> !$past(i_nmi_n, 3)) else $error("nmi early");
endmodule

bind rsc_ctrl rsc_ctrl_asserts rsc_ctrl_asserts_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_clock_ratio_strap(i_clock_ratio_strap), .i_byte_order_strap(i_byte_order_strap),
  .i_bus_protocol_strap(i_bus_protocol_strap), .i_pll_halt_n(i_pll_halt_n), .i_nmi_n(i_nmi_n),
  .o_ratio_code_field(o_ratio_code_field), .o_big_endian(o_big_endian), .o_protocol_9bit(o_protocol_9bit),
  .o_system_bus_clock_en(o_system_bus_clock_en), .o_core_clock_run(o_core_clock_run),
  .o_irq(o_irq), .o_nmi(o_nmi));

// ==== bench/rsc_board.sv ====
// Board model: cold reset, strap pins, control pins and interrupt sources
module rsc_board (
  // Clock
  input wire logic i_clk,
  // Pins toward the block
  output logic o_arst_n,
  output logic [1:0] o_ratio,
  output logic o_endian,
  output logic o_proto,
  output logic o_pll_n,
  output logic o_inh,
  output logic [3:0] o_gp_n,
  output logic o_nmi_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Interrupt lines rest at their pull-up level
  initial begin
    o_arst_n = 1'b0;
    {o_ratio, o_endian, o_proto, o_inh} = 5'h00;
    {o_pll_n, o_gp_n, o_nmi_n} = 6'h3f;
  end
  task automatic straps(input logic [1:0] r, input logic e, input logic p);
    o_ratio <= r;
    o_endian <= e;
    o_proto <= p;
  endtask
  task automatic power(input logic [1:0] r, input logic e, input logic p);
    @(posedge i_clk);
    o_arst_n <= 1'b0;
    straps(r, e, p);
    repeat (8) @(posedge i_clk);
    o_arst_n <= 1'b1;
  endtask
  task automatic ctl(input logic pll, input logic inh);
    o_pll_n <= pll;
    o_inh <= inh;
  endtask
  task automatic irq(input logic [3:0] gp, input logic nmi);
    o_gp_n <= gp;
    o_nmi_n <= nmi;
  endtask
endmodule

// ==== bench/rsc_ctrl_tb.sv ====
// Self-checking bench of the strap, clock and interrupt block
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module rsc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [11:0] cds = {3'h1, 3'h0, 3'h7, 3'h2};
  int pls [4] = '{15, 24, 30, 20};
  int err_total = 0;
  int samples_checked = 0;
  int c;
  wire logic arst_n, endian, proto, pll_n, inh, nmi_n, big, p9, bus_en, run, lp, irq, nmi, wreq;
  wire logic [1:0] ratio;
  wire logic [3:0] gp_n;
  wire logic [2:0] code;
  wire logic [31:0] rdata;
  always #2 i_clk = ~i_clk;
  rsc_board rsc_board_i (.i_clk(i_clk), .o_arst_n(arst_n), .o_ratio(ratio), .o_endian(endian),
    .o_proto(proto), .o_pll_n(pll_n), .o_inh(inh), .o_gp_n(gp_n), .o_nmi_n(nmi_n));
  rsc_ctrl rsc_ctrl_i (.i_clk(i_clk), .i_arst_n(arst_n), .i_clock_ratio_strap(ratio),
    .i_byte_order_strap(endian), .i_bus_protocol_strap(proto), .i_pll_halt_n(pll_n),
    .i_timer_irq_inhibit(inh), .i_gp_irq_n(gp_n), .i_nmi_n(nmi_n), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_ratio_code_field(code), .o_big_endian(big),
    .o_protocol_9bit(p9), .o_system_bus_clock_en(bus_en), .o_core_clock_run(run),
    .o_low_power_indicator(lp), .o_irq(irq), .o_nmi(nmi));
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wd <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 40) begin
      err_total++;
      end_of_test;
    end
  endtask
  task automatic cnt;
    c = 0;
    repeat (60) begin
      @(posedge i_clk);
      c += int'(bus_en === 1'b1);
    end
  endtask
  initial begin
    for (int k = 0; k < 4; k++) begin
      rsc_board_i.power(k[1:0], k[0], k[1]);
      repeat (4) @(posedge i_clk);
      `CHK("code", cds[k * 3 +: 3], code)
      `CHK("endian", k[0], big)
      `CHK("proto", k[1], p9)
      cnt;
      `CHK("pulses", pls[k], c)
    end
    rsc_board_i.straps(2'h0, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    `CHK("held", 5'h07, {code, big, p9})
    acc(1'b1, 5'h00, 32'hffffffff);
    acc(1'b0, 5'h00, 32'h0);
    `CHK("strap reg", 32'h67, rd)
    acc(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int d = 0; d < 4; d++) begin
      acc(1'b1, 5'h04, 32'(d));
      @(posedge i_clk);
      `CHK("low power", d != 0, lp)
      acc(1'b0, 5'h04, 32'h0);
      `CHK("ctrl", 32'(d), rd)
    end
    acc(1'b1, 5'h10, 32'h0);
    rsc_board_i.irq(4'h0, 1'b1);
    repeat (8) @(posedge i_clk);
    `CHK("masked", 1'b0, irq)
    acc(1'b0, 5'h08, 32'h0);
    `CHK("stat all", 32'h0f, rd)
    rsc_board_i.irq(4'hf, 1'b1);
    acc(1'b1, 5'h10, 32'h0f);
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 5'h0c, 32'h3f);
      rsc_board_i.irq(~(4'h1 << k), 1'b1);
      repeat (6) @(posedge i_clk);
      `CHK("gp irq", 1'b1, irq)
      acc(1'b0, 5'h08, 32'h0);
      `CHK("gp stat", 32'h1 << k, rd)
      rsc_board_i.irq(4'hf, 1'b1);
      repeat (6) @(posedge i_clk);
    end
    acc(1'b1, 5'h0c, 32'h3f);
    acc(1'b1, 5'h10, 32'h0);
    `CHK("cleared", 1'b0, irq)
    rsc_board_i.irq(4'hf, 1'b0);
    repeat (8) @(posedge i_clk);
    `CHK("nmi", 2'h3, {nmi, irq})
    rsc_board_i.irq(4'hf, 1'b1);
    acc(1'b1, 5'h0c, 32'h10);
    repeat (2) @(posedge i_clk);
    `CHK("nmi clear", 1'b0, nmi)
    rsc_board_i.ctl(1'b1, 1'b1);
    acc(1'b1, 5'h10, 32'h20);
    acc(1'b1, 5'h14, 32'h1);
    repeat (30) @(posedge i_clk);
    `CHK("timer off", 1'b0, irq)
    rsc_board_i.ctl(1'b1, 1'b0);
    repeat (30) @(posedge i_clk);
    acc(1'b0, 5'h08, 32'h0);
    `CHK("timer on", 32'h20, rd)
    acc(1'b1, 5'h14, 32'h0);
    rsc_board_i.ctl(1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    `CHK("halted", 1'b0, run)
    cnt;
    `CHK("halt pulses", 0, c)
    rsc_board_i.ctl(1'b1, 1'b0);
    repeat (4) @(posedge i_clk);
    cnt;
    `CHK("run pulses", 20, c)
    acc(1'b0, 5'h18, 32'h0);
    `CHK("live", 32'h20, rd)
    end_of_test;
  end
endmodule
